// [logic/ebr_regs.vh]
// Purpose: Constants for the external bus ready/hold arbitration block
// Assumes: AXI4-Lite register bus, 32-bit data, byte addresses
// Notes: Offsets are byte addresses of aligned words
`ifndef EBR_REGS_VH
`define EBR_REGS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define EBR_OFF_CTRL 4'h0
`define EBR_OFF_STAT 4'h4
`define EBR_OFF_CMD 4'h8
// ----------------------------------------
// Control fields
// ----------------------------------------
`define EBR_CTRL_MCWS_LSB 0
`define EBR_CTRL_MCWS_MSB 3
`define EBR_CTRL_RWDLY 4
`define EBR_CTRL_MUX 5
`define EBR_CTRL_TRIWS 6
`define EBR_CTRL_HOLDEN 7
`define EBR_CTRL_REGAIN 8
`define EBR_CTRL_RESET 32'h0000_0000
// ----------------------------------------
// Status fields
// ----------------------------------------
`define EBR_STAT_BUSY 0
`define EBR_STAT_GRANT 1
`define EBR_STAT_REGREQ 2
`define EBR_STAT_RDYWS_LSB 8
`define EBR_STAT_RDYWS_MSB 15
`define EBR_STAT_CYC_LSB 16
`define EBR_STAT_CYC_MSB 31
// ----------------------------------------
// Command fields
// ----------------------------------------
`define EBR_CMD_START 0
`define EBR_CMD_WRITE 1
// ----------------------------------------
// Bus answers
// ----------------------------------------
`define EBR_RESP_OKAY 2'h0
`define EBR_RESP_SLVERR 2'h2
`endif

// [logic/ebr_axil_slave.v]
// Purpose: AXI4-Lite slave front end for the bus controller registers
// Assumes: One write and one read outstanding at most
// Notes: Write answer one cycle after both halves held, read answer one cycle after address
`timescale 1ns/1ns
`include "ebr_regs.vh"
module ebr_axil_slave (
    // Clock and reset
    input wire clk_sys,
    input wire nrst,
    // Write channels
    input wire [3:0] awaddr,
    input wire awvalid,
    output reg awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output reg wready,
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    // Read channels
    input wire [3:0] araddr,
    input wire arvalid,
    output reg arready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    // Register side
    output reg [31:0] ctrlReg,
    output reg cmdPulse,
    output reg cmdWrite,
    input wire [31:0] statusWord
);
    reg [3:0] awAddrReg;
    reg awHeld;
    reg [31:0] wDataReg;
    reg [3:0] wStrbReg;
    reg wHeld;
    integer i;

    // ----------------------------------------
    // Write path
    // ----------------------------------------
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            awready <= 1'b1;
            wready <= 1'b1;
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddrReg <= 4'h0;
            wDataReg <= 32'h0000_0000;
            wStrbReg <= 4'h0;
            bvalid <= 1'b0;
            bresp <= `EBR_RESP_OKAY;
            ctrlReg <= `EBR_CTRL_RESET;
            cmdPulse <= 1'b0;
            cmdWrite <= 1'b0;
        end else begin
            cmdPulse <= 1'b0;
            if (awvalid && awready) begin
                awAddrReg <= awaddr;
                awHeld <= 1'b1;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                wDataReg <= wdata;
                wStrbReg <= wstrb;
                wHeld <= 1'b1;
                wready <= 1'b0;
            end
            if (awHeld && wHeld && !bvalid) begin
                bvalid <= 1'b1;
                bresp <= `EBR_RESP_OKAY;
                case (awAddrReg)
                    `EBR_OFF_CTRL: begin
                        for (i = 0; i < 4; i = i + 1) begin
                            if (wStrbReg[i]) begin
                                ctrlReg[i*8 +: 8] <= wDataReg[i*8 +: 8];
                            end
                        end
                    end
                    `EBR_OFF_CMD: begin
                        // Start only when the low lane is written
                        if (wStrbReg[0]) begin
                            cmdPulse <= wDataReg[`EBR_CMD_START];
                            cmdWrite <= wDataReg[`EBR_CMD_WRITE];
                        end
                    end
                    `EBR_OFF_STAT: begin
                        bresp <= `EBR_RESP_OKAY;
                    end
                    default: begin
                        bresp <= `EBR_RESP_SLVERR;
                    end
                endcase
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `EBR_RESP_OKAY;
        end else begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rresp <= `EBR_RESP_OKAY;
                case (araddr)
                    `EBR_OFF_CTRL: rdata <= ctrlReg;
                    `EBR_OFF_STAT: rdata <= statusWord;
                    `EBR_OFF_CMD: rdata <= 32'h0000_0000;
                    default: begin
                        rdata <= 32'h0000_0000;
                        rresp <= `EBR_RESP_SLVERR;
                    end
                endcase
            end
            if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end
endmodule // ebr_axil_slave

// [logic/ebr_bus_ctrl.v]
// Purpose: External bus cycle sequencer with ready wait states and hold arbitration
// Assumes: Ready and hold inputs synchronous to clk_sys; one clk_sys cycle per bus state
// Notes: Pins are active low where named _n; chip selects float via enable when released
// Function
// - Ready high at sampling inserts wait state; ready low ends cycle.
// - Cycle runs programmed length with memory-cycle wait states before sampling.
// - Strobe leading edge placed by the read/write delay option.
// - Multiplexed mode appends extra wait, optionally a tristate wait.
// - Gap before next cycle: three cycles muxed with tristate, one demuxed.
// - Hold request granted only after the running bus cycle finishes.
// - Released chip selects are undriven, left to pull-ups.
// - Regain request asserted no earlier than after release and grant.
// - Regain sequence begins when hold input goes high or the hold enable bit is cleared.
// - Hold deassertion is honoured even without a regain request.
// - Next self-driven cycle may start after grant withdrawn.
`timescale 1ns/1ns
`include "ebr_regs.vh"
module ebr_bus_ctrl (
    // Clock and reset
    input wire clk_sys,
    input wire nrst,
    // AXI4-Lite write channels
    input wire [3:0] awaddr,
    input wire awvalid,
    output wire awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output wire wready,
    output wire [1:0] bresp,
    output wire bvalid,
    input wire bready,
    // AXI4-Lite read channels
    input wire [3:0] araddr,
    input wire arvalid,
    output wire arready,
    output wire [31:0] rdata,
    output wire [1:0] rresp,
    output wire rvalid,
    input wire rready,
    // External bus pins
    input wire ready_n,
    output reg rdStrobe_n,
    output reg wrStrobe_n,
    output reg [4:0] chip_select_lines,
    output reg chipSelOe_n,
    output reg busOe_n,
    output reg system_clock_output,
    // Arbitration pins
    input wire hold_n,
    output reg hold_grant_out,
    output reg bus_regain_request
);
    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam [3:0] ST_IDLE = 4'h0;
    localparam [3:0] ST_ADDR = 4'h1;
    localparam [3:0] ST_DELAY = 4'h2;
    localparam [3:0] ST_MEMWS = 4'h3;
    localparam [3:0] ST_SAMPLE = 4'h4;
    localparam [3:0] ST_MUXWS = 4'h5;
    localparam [3:0] ST_TRIWS = 4'h6;
    localparam [3:0] ST_FLOAT = 4'h7;
    localparam [3:0] ST_GRANTED = 4'h8;
    localparam [3:0] ST_REGAIN = 4'h9;

    wire [31:0] ctrlReg;
    wire cmdPulse;
    wire cmdWrite;
    wire [31:0] statusWord;
    reg [3:0] state_reg;
    reg [3:0] state_next;
    reg [3:0] wsCnt_reg;
    reg [3:0] wsCnt_next;
    reg [7:0] rdyWs_reg;
    reg [15:0] cycCnt_reg;
    reg pend_reg;
    reg pendWrite_reg;
    reg curWrite_reg;
    reg strobe_next;

    wire [3:0] memWs = ctrlReg[`EBR_CTRL_MCWS_MSB:`EBR_CTRL_MCWS_LSB];
    wire rwDelay = ctrlReg[`EBR_CTRL_RWDLY];
    wire muxMode = ctrlReg[`EBR_CTRL_MUX];
    wire triWs = ctrlReg[`EBR_CTRL_TRIWS];
    wire holdEn = ctrlReg[`EBR_CTRL_HOLDEN];
    wire regainWant = ctrlReg[`EBR_CTRL_REGAIN];
    wire holdReq = holdEn && !hold_n;

    // Decoded three times: strobe drive, chip select and busy flag
    function inBusCycle;
        input [3:0] st;
        begin
            inBusCycle = (st == ST_ADDR) || (st == ST_DELAY) || (st == ST_MEMWS) || (st == ST_SAMPLE);
        end
    endfunction

    // Status shows the regain request as active high, unlike its pin
    assign statusWord = {cycCnt_reg, rdyWs_reg, 5'h00, ~bus_regain_request,
                         ~hold_grant_out, inBusCycle(state_reg) | pend_reg};

    ebr_axil_slave uRegs (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .ctrlReg(ctrlReg),
        .cmdPulse(cmdPulse),
        .cmdWrite(cmdWrite),
        .statusWord(statusWord)
    );

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always @* begin
        state_next = state_reg;
        wsCnt_next = wsCnt_reg;
        case (state_reg)
            ST_IDLE: begin
                if (holdReq) begin
                    state_next = ST_FLOAT;
                end else if (pend_reg) begin
                    state_next = ST_ADDR;
                end
            end
            ST_ADDR: begin
                wsCnt_next = memWs;
                // Delayed strobe spends one extra state before command edge
                state_next = rwDelay ? ST_DELAY : ST_MEMWS;
            end
            ST_DELAY: begin
                state_next = ST_MEMWS;
            end
            ST_MEMWS: begin
                if (wsCnt_reg == 4'h0) begin
                    state_next = ST_SAMPLE;
                end else begin
                    wsCnt_next = wsCnt_reg - 4'h1;
                end
            end
            ST_SAMPLE: begin
                if (!ready_n) begin
                    // Demuxed bus without tristate wait: next cycle after one idle state
                    state_next = muxMode ? ST_MUXWS : ST_IDLE;
                end
            end
            ST_MUXWS: begin
                state_next = triWs ? ST_TRIWS : ST_IDLE;
            end
            ST_TRIWS: begin
                state_next = ST_IDLE;
            end
            ST_FLOAT: begin
                state_next = ST_GRANTED;
            end
            ST_GRANTED: begin
                if (hold_n || !holdEn) begin
                    state_next = ST_REGAIN;
                end
            end
            ST_REGAIN: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Strobe active from command edge through the sampling state
    always @* begin
        case (state_next)
            ST_DELAY: strobe_next = 1'b0;
            ST_ADDR: strobe_next = 1'b0;
            default: strobe_next = inBusCycle(state_next);
        endcase
    end

    // ----------------------------------------
    // State and pin registers
    // ----------------------------------------
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
            wsCnt_reg <= 4'h0;
            rdyWs_reg <= 8'h00;
            cycCnt_reg <= 16'h0000;
            pend_reg <= 1'b0;
            pendWrite_reg <= 1'b0;
            curWrite_reg <= 1'b0;
            rdStrobe_n <= 1'b1;
            wrStrobe_n <= 1'b1;
            chip_select_lines <= 5'h1F;
            chipSelOe_n <= 1'b0;
            busOe_n <= 1'b0;
            system_clock_output <= 1'b0;
            hold_grant_out <= 1'b1;
            bus_regain_request <= 1'b1;
        end else begin
            state_reg <= state_next;
            wsCnt_reg <= wsCnt_next;
            system_clock_output <= ~system_clock_output;
            // Command taken in any state; queue holds one request
            if (cmdPulse) begin
                pend_reg <= 1'b1;
                pendWrite_reg <= cmdWrite;
            end else if (state_reg == ST_IDLE && state_next == ST_ADDR) begin
                pend_reg <= 1'b0;
            end
            if (state_next == ST_ADDR) begin
                curWrite_reg <= pendWrite_reg;
                rdyWs_reg <= 8'h00;
                cycCnt_reg <= cycCnt_reg + 16'h0001;
            end else if (state_reg == ST_SAMPLE && ready_n && rdyWs_reg != 8'hFF) begin
                rdyWs_reg <= rdyWs_reg + 8'h01;
            end
            rdStrobe_n <= ~(strobe_next && !(state_next == ST_ADDR ? pendWrite_reg : curWrite_reg));
            wrStrobe_n <= ~(strobe_next && (state_next == ST_ADDR ? pendWrite_reg : curWrite_reg));
            chip_select_lines <= inBusCycle(state_next) ? 5'h1E : 5'h1F;
            // Float first, grant one state later
            if (state_next == ST_FLOAT) begin
                chipSelOe_n <= 1'b1;
                busOe_n <= 1'b1;
            end
            if (state_reg == ST_FLOAT) begin
                hold_grant_out <= 1'b0;
            end
            if (state_reg == ST_GRANTED && state_next == ST_REGAIN) begin
                hold_grant_out <= 1'b1;
            end
            if (state_reg == ST_REGAIN) begin
                chipSelOe_n <= 1'b0;
                busOe_n <= 1'b0;
                bus_regain_request <= 1'b1;
            // Not on the edge that leaves the grant, or it would fall after regain began
            end else if (state_next == ST_GRANTED && !hold_grant_out && regainWant && pend_reg) begin
                bus_regain_request <= 1'b0;
            end
        end
    end
endmodule // ebr_bus_ctrl

// [dv/ebr_bus_ctrl_asserts.sv]
// Purpose: Port checks for the bus sequencer and hold arbitration
// Assumes: Ready and hold synchronous to clk_sys
// Notes: Bound to every ebr_bus_ctrl instance
`timescale 1ns/1ns
module ebr_bus_ctrl_asserts (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // External bus
    input wire logic ready_n,
    input wire logic rdStrobe_n,
    input wire logic wrStrobe_n,
    input wire logic [4:0] chip_select_lines,
    input wire logic chipSelOe_n,
    input wire logic busOe_n,
    input wire logic system_clock_output,
    // Arbitration
    input wire logic hold_n,
    input wire logic hold_grant_out,
    input wire logic bus_regain_request
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    a_ready_ends: assert property ($rose(rdStrobe_n) || $rose(wrStrobe_n) |-> !$past(ready_n))
        else $error("strobe ended without ready low");
    a_cs_min_len: assert property ($fell(chip_select_lines[0]) |-> (!chip_select_lines[0]) [*3])
        else $error("cycle shorter than three states");
    a_strobe_in_cs: assert property (!rdStrobe_n || !wrStrobe_n |-> !chip_select_lines[0])
        else $error("strobe outside chip select");
    a_strobe_late: assert property ($fell(rdStrobe_n) || $fell(wrStrobe_n) |-> !$past(chip_select_lines[0]))
        else $error("strobe began with address state");
    a_grant_float: assert property ($fell(hold_grant_out) |-> $past(busOe_n) && chipSelOe_n)
        else $error("grant before bus floated");
    a_granted_idle: assert property (!hold_grant_out |-> chipSelOe_n && busOe_n && rdStrobe_n && wrStrobe_n)
        else $error("bus active while granted");
    a_regain_late: assert property ($fell(bus_regain_request) |-> !hold_grant_out)
        else $error("regain request before grant");
    a_grant_kept: assert property (!hold_grant_out && !hold_n |=> !hold_grant_out)
        else $error("bus taken back while hold low");
    a_hold_release: assert property (!hold_grant_out && hold_n |-> ##[1:3] hold_grant_out)
        else $error("hold release not honoured");
    a_drive_after: assert property ($fell(busOe_n) |-> hold_grant_out && $past(hold_grant_out))
        else $error("bus driven before grant withdrawn");
    a_regain_drop: assert property ($rose(hold_grant_out) |-> ##[0:2] bus_regain_request)
        else $error("regain request kept after regain");
    a_system_clock_output_toggle: assert property (nrst && $past(nrst) |-> system_clock_output != $past(system_clock_output))
        else $error("clock output pin stalled");
    c_grant: cover property ($fell(hold_grant_out));
    c_regain: cover property ($fell(bus_regain_request));
    c_write: cover property ($rose(wrStrobe_n));
endmodule // ebr_bus_ctrl_asserts

bind ebr_bus_ctrl ebr_bus_ctrl_asserts uChk (.*);

// [dv/ebr_ext_slave.sv]
// Purpose: External slave answering ready, plus chip select pull-ups
// Assumes: Ready level sampled by the sequencer on clk_sys
// Notes: readyDelay counts strobe-low edges before ready drops
`timescale 1ns/1ns
module ebr_ext_slave (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Strobes and answer
    input wire logic rdStrobe_n,
    input wire logic wrStrobe_n,
    input wire logic [7:0] readyDelay,
    output logic ready_n,
    // Chip selects
    input wire logic [4:0] chip_select_lines,
    input wire logic chipSelOe_n,
    output logic [4:0] csWire
);
    logic [7:0] lowCnt;
    wire strobeLow = !rdStrobe_n || !wrStrobe_n;
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) lowCnt <= 8'h00;
        else lowCnt <= strobeLow ? lowCnt + 8'h01 : 8'h00;
    end
    // Ready withdrawn with the trailing strobe edge, so it never lingers
    assign ready_n = !(strobeLow && lowCnt >= readyDelay);
    // Released selects float to the pull-ups
    assign csWire = chipSelOe_n ? 5'h1F : chip_select_lines;
endmodule // ebr_ext_slave

// [dv/test_ext_bus_ready_and_hold_arbitration.sv]
// Purpose: Self-checking bench for the bus sequencer and hold arbitration
// Assumes: Slave model drops ready after a set strobe-low count
// Notes: Lengths and gaps counted in clk_sys states at falling edges
`timescale 1ns/1ns
`include "ebr_regs.vh"
module test_ext_bus_ready_and_hold_arbitration;
    logic clk_sys, nrst, awvalid, wvalid, bready, arvalid, rready, hold_n, hA, hW, hB, wr;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rd;
    logic [7:0] readyDelay;
    logic [1:0] rs;
    logic [15:0] cfg [0:3];
    wire awready, wready, bvalid, arready, rvalid, ready_n, rdStrobe_n, wrStrobe_n, chipSelOe_n, busOe_n;
    wire hold_grant_out, bus_regain_request;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [4:0] chip_select_lines, csWire;
    integer n_fail, n_compared, i, t, len, st, gap, nCyc;
    ebr_bus_ctrl DUT (.clk_sys(clk_sys), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .ready_n(ready_n), .rdStrobe_n(rdStrobe_n), .wrStrobe_n(wrStrobe_n),
        .chip_select_lines(chip_select_lines), .chipSelOe_n(chipSelOe_n), .busOe_n(busOe_n),
        .system_clock_output(), .hold_n(hold_n), .hold_grant_out(hold_grant_out),
        .bus_regain_request(bus_regain_request));
    ebr_ext_slave uSlave (.clk_sys(clk_sys), .nrst(nrst), .rdStrobe_n(rdStrobe_n), .wrStrobe_n(wrStrobe_n),
        .readyDelay(readyDelay), .ready_n(ready_n), .chip_select_lines(chip_select_lines),
        .chipSelOe_n(chipSelOe_n), .csWire(csWire));
    task give_verdict;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task tmo;
        n_fail = n_fail + 1;
        $display("BAD %0t wait ran out", $time);
        give_verdict();
    endtask
    task check(input logic [31:0] got, input logic [31:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task axiWr(input logic [3:0] a, input logic [31:0] d);
        integer k;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        hB = 1'b0;
        for (k = 0; !hB; k = k + 1) begin
            if (k > 60) tmo();
            @(negedge clk_sys);
            hA = awvalid & awready;
            hW = wvalid & wready;
            hB = bvalid;
            @(posedge clk_sys);
            if (hA) awvalid <= 1'b0;
            if (hW) wvalid <= 1'b0;
            if (hB) bready <= 1'b0;
        end
        @(posedge clk_sys);
    endtask
    task axiRd(input logic [3:0] a);
        integer k;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        hB = 1'b0;
        for (k = 0; !hB; k = k + 1) begin
            if (k > 60) tmo();
            @(negedge clk_sys);
            hA = arvalid & arready;
            hB = rvalid;
            rd = rdata;
            rs = rresp;
            @(posedge clk_sys);
            if (hA) arvalid <= 1'b0;
            if (hB) rready <= 1'b0;
        end
        @(posedge clk_sys);
    endtask
    // Gap is meaningful only when called right after a previous cycle
    task measure(output integer cl, output integer sl, output integer gl);
        integer k;
        cl = 0;
        sl = 0;
        gl = 0;
        for (k = 0; chip_select_lines[0] !== 1'b0; k = k + 1) begin
            if (k > 90) tmo();
            @(negedge clk_sys);
            gl = gl + 1;
        end
        for (k = 0; chip_select_lines[0] === 1'b0; k = k + 1) begin
            if (k > 90) tmo();
            cl = cl + 1;
            if ((wr ? wrStrobe_n : rdStrobe_n) === 1'b0) sl = sl + 1;
            @(negedge clk_sys);
        end
    endtask
    task waitGrant;
        for (t = 0; hold_grant_out !== 1'b0; t = t + 1) begin
            if (t > 90) tmo();
            @(negedge clk_sys);
        end
        @(posedge clk_sys);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial begin
        // Encoding: [3:0] waits, [4] delay, [5] mux, [6] tristate, [7] write, [11:8] ready waits
        cfg[0] = 16'h0600;
        cfg[1] = 16'h0793;
        cfg[2] = 16'h0661;
        cfg[3] = 16'h06BF;
        nrst = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, wr} = 6'h00;
        hold_n = 1'b1;
        {awaddr, araddr, wstrb, wdata} = {8'h00, 4'hF, 32'h0};
        readyDelay = 8'h00;
        n_fail = 0;
        n_compared = 0;
        nCyc = 0;
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        axiRd(`EBR_OFF_CTRL);
        check(rd, `EBR_CTRL_RESET);
        axiRd(4'hC);
        check({rs, rd[29:0]}, {`EBR_RESP_SLVERR, 30'h0});
        // Second command lands while the first cycle still runs
        for (i = 0; i < 4; i = i + 1) begin
            wr = cfg[i][7];
            axiWr(`EBR_OFF_CTRL, {25'h0, cfg[i][6:0]});
            readyDelay <= {4'h0, cfg[i][3:0]} + {4'h0, cfg[i][11:8]} + 8'h01;
            fork
                begin
                    axiWr(`EBR_OFF_CMD, {30'h0, wr, 1'b1});
                    axiWr(`EBR_OFF_CMD, {30'h0, wr, 1'b1});
                end
                begin
                    measure(len, st, gap);
                    measure(len, st, gap);
                end
            join
            check(len, 3 + cfg[i][4] + cfg[i][3:0] + cfg[i][11:8]);
            check(st, 2 + cfg[i][3:0] + cfg[i][11:8]);
            check(gap, 1 + cfg[i][5] + cfg[i][6]);
            nCyc = nCyc + 2;
            @(posedge clk_sys);
            axiRd(`EBR_OFF_STAT);
            check(rd, {nCyc[15:0], 4'h0, cfg[i][11:8], 8'h00});
        end
        wr = 1'b0;
        axiWr(`EBR_OFF_CTRL, 32'h0000_0180);
        readyDelay <= 8'h09;
        axiWr(`EBR_OFF_CMD, 32'h0000_0001);
        hold_n <= 1'b0;
        waitGrant();
        check({27'h0, csWire}, 32'h1F);
        nCyc = nCyc + 1;
        axiRd(`EBR_OFF_STAT);
        check(rd, {nCyc[15:0], 8'h08, 8'h02});
        axiWr(`EBR_OFF_CMD, 32'h0000_0001);
        for (t = 0; bus_regain_request !== 1'b0; t = t + 1) begin
            if (t > 90) tmo();
            @(negedge clk_sys);
        end
        check({27'h0, csWire}, 32'h1F);
        @(posedge clk_sys);
        hold_n <= 1'b1;
        measure(len, st, gap);
        check({30'h0, hold_grant_out, bus_regain_request}, 32'h3);
        check(len, 32'd11);
        @(posedge clk_sys);
        axiWr(`EBR_OFF_CTRL, 32'h0000_0080);
        hold_n <= 1'b0;
        waitGrant();
        axiWr(`EBR_OFF_CMD, 32'h0000_0001);
        check({31'h0, bus_regain_request}, 32'h1);
        hold_n <= 1'b1;
        measure(len, st, gap);
        check(len, 32'd11);
        give_verdict();
    end
endmodule // test_ext_bus_ready_and_hold_arbitration
